// >>> sesev_flag_reg.sv
// Sticky clear-on-read flag register; a set in the clearing cycle survives
`timescale 1ns/1ps
`include "sesev_regs.svh"

module sesev_flag_reg
  import sesev_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire logic [`SESEV_FLAG_W-1:0]  set_vec,
  input  wire logic                      clear,
  output logic [`SESEV_FLAG_W-1:0]       flags_q
);

  logic [`SESEV_FLAG_W-1:0] flags_d;

  // ==========================================================================
  // Set wins over clear
  always_comb begin
    flags_d = (clear ? `SESEV_STATUS_RST : flags_q) | set_vec;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags_q <= `SESEV_STATUS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// >>> sesev_pkg.sv
// Types shared by the SerDes event status bank
package sesev_pkg;

  // ==========================================================================
  // Auto-negotiation state as reported by the PCS, one-hot
  typedef enum logic [6:0] {
    SESEV_AN_OTHER        = 7'b0000001,
    SESEV_AN_ENABLE       = 7'b0000010,
    SESEV_AN_OFF_LINK_OK  = 7'b0000100,
    SESEV_AN_ABILITY_DET  = 7'b0001000,
    SESEV_AN_ACK_DET      = 7'b0010000,
    SESEV_AN_COMPLETE_ACK = 7'b0100000,
    SESEV_AN_IDLE_DET     = 7'b1000000
  } sesev_an_state_t;

  // ==========================================================================
  // Per-port indications from the PCS
  typedef struct packed {
    logic            sgmii_mode;
    logic            code_word_incompatible;
    logic            negotiation_error_seen;
    logic            page_rx_valid;
    logic            page_selector_bit;
    logic            sync_status;
    logic            rudi_c;
    logic            rudi_i;
    logic            rudi_invalid;
    logic            link_up;
    sesev_an_state_t an_state;
  } sesev_pcs_in_t;

  // ==========================================================================
  // Bus answer FSM
  typedef enum logic [1:0] {
    SESEV_BUS_IDLE = 2'b01,
    SESEV_BUS_DONE = 2'b10
  } sesev_bus_state_t;

endpackage

// >>> sesev_port_detect.sv
// Per-port event detector: edges, state entries and sync-loss timer
`timescale 1ns/1ps
`include "sesev_regs.svh"

module sesev_port_detect
  import sesev_pkg::*;
#(
  parameter int LOSS_CYCLES = 100000
) (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire sesev_pcs_in_t             pcs_in,
  output logic [`SESEV_FLAG_W-1:0]       events
);

  logic                          primed_q;
  logic                          mode_prev_q;
  logic                          sync_prev_q;
  logic [`SESEV_AN_STATE_W-1:0]  an_prev_q;
  logic [`SESEV_LOSS_CNT_W-1:0]  loss_cnt_q;
  logic                          loss_armed_q;
  logic                          loss_hit;
  logic [`SESEV_AN_STATE_W-1:0]  an_entry;

  // ==========================================================================
  // History; edges are ignored until one sample has been taken
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      primed_q    <= 1'b0;
      mode_prev_q <= 1'b0;
      sync_prev_q <= 1'b0;
      an_prev_q   <= SESEV_AN_OTHER;
    end else begin
      primed_q    <= 1'b1;
      mode_prev_q <= pcs_in.sgmii_mode;
      sync_prev_q <= pcs_in.sync_status;
      an_prev_q   <= pcs_in.an_state;
    end
  end

  // ==========================================================================
  // Sync-loss timer; fires once per loss while the link is up
  assign loss_hit = loss_armed_q && pcs_in.link_up &&
                    (loss_cnt_q == LOSS_CYCLES[`SESEV_LOSS_CNT_W-1:0]);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      loss_cnt_q   <= '0;
      loss_armed_q <= 1'b1;
    end else if (pcs_in.sync_status) begin
      loss_cnt_q   <= '0;
      loss_armed_q <= 1'b1;
    end else begin
      if (loss_cnt_q != LOSS_CYCLES[`SESEV_LOSS_CNT_W-1:0]) begin
        loss_cnt_q <= loss_cnt_q + 1'b1;
      end
      if (loss_hit) begin
        loss_armed_q <= 1'b0;
      end
    end
  end

  assign an_entry = primed_q ? (pcs_in.an_state & ~an_prev_q) : '0;

  // ==========================================================================
  // Event vector, one pulse per occurrence
  always_comb begin
    events = '0;
    events[`SESEV_B_MODE_TOGGLED]   = primed_q && (pcs_in.sgmii_mode != mode_prev_q);
    events[`SESEV_B_CODE_INCOMPAT]  = pcs_in.code_word_incompatible;
    events[`SESEV_B_NEG_ERROR]      = pcs_in.negotiation_error_seen;
    events[`SESEV_B_SEL_CONFLICT]   = pcs_in.sgmii_mode && pcs_in.page_rx_valid &&
                                      !pcs_in.page_selector_bit;
    events[`SESEV_B_SYNC_FAIL]      = primed_q && sync_prev_q && !pcs_in.sync_status;
    events[`SESEV_B_SYNC_OK]        = primed_q && !sync_prev_q && pcs_in.sync_status;
    events[`SESEV_B_RUDI_C]         = pcs_in.rudi_c;
    events[`SESEV_B_RUDI_I]         = pcs_in.rudi_i;
    events[`SESEV_B_RUDI_INVALID]   = pcs_in.rudi_invalid;
    events[`SESEV_B_LINK_DROPPED]   = loss_hit;
    events[`SESEV_B_IDLE_DETECT]    = an_entry[6];
    events[`SESEV_B_COMPLETE_ACK]   = an_entry[5];
    events[`SESEV_B_ACK_DETECT]     = an_entry[4];
    events[`SESEV_B_ABILITY_DETECT] = an_entry[3];
    events[`SESEV_B_NEG_OFF_LINK]   = an_entry[2];
    events[`SESEV_B_NEG_ENABLE]     = an_entry[1];
  end

endmodule

// >>> sesev_regs.svh
// Register map, field positions, reset values and timing for the SerDes event status bank
`ifndef SESEV_REGS_SVH
`define SESEV_REGS_SVH

// ==========================================================================
// Bus and port geometry
`define SESEV_ADDR_W         18
`define SESEV_NUM_PORTS      16
`define SESEV_FLAG_W         16
`define SESEV_AN_STATE_W     7

// ==========================================================================
// Register indices (byte address = index * 4)
`define SESEV_PAGE_FIRST     8'h10
`define SESEV_PAGE_LAST      8'h1F
`define SESEV_STATUS2_IDX    8'h2A
`define SESEV_CTRL_IDX       16'h3F00
`define SESEV_PEND_IDX       16'h3F01

// ==========================================================================
// Event flag positions
`define SESEV_B_MODE_TOGGLED   15
`define SESEV_B_CODE_INCOMPAT  14
`define SESEV_B_NEG_ERROR      13
`define SESEV_B_SEL_CONFLICT   12
`define SESEV_B_SYNC_FAIL      11
`define SESEV_B_SYNC_OK        10
`define SESEV_B_RUDI_C         9
`define SESEV_B_RUDI_I         8
`define SESEV_B_RUDI_INVALID   7
`define SESEV_B_LINK_DROPPED   6
`define SESEV_B_IDLE_DETECT    5
`define SESEV_B_COMPLETE_ACK   4
`define SESEV_B_ACK_DETECT     3
`define SESEV_B_ABILITY_DETECT 2
`define SESEV_B_NEG_OFF_LINK   1
`define SESEV_B_NEG_ENABLE     0

// ==========================================================================
// Reset values
`define SESEV_STATUS_RST     16'h0000
`define SESEV_CTRL_RST       16'hFFFF
`define SESEV_DATA_ZERO      32'h0000_0000

// ==========================================================================
// Timing
`define SESEV_CLK_PERIOD_NS  100
`define SESEV_LINK_LOSS_MS   10
`define SESEV_NS_PER_MS      1000000
`define SESEV_LOSS_CNT_W     17

`endif

// >>> sesev_status_bank.sv
// APB register bank of per-port SerDes event status flags
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "sesev_regs.svh"

// Summary of operation
// - One 16-bit event register per port, pages 10h-1Fh, offset 2Ah.
// - Bit 15 latches when the port changes between SGMII and SerDes.
// - Bit 14 latches on incompatible local and remote link code words.
// - Bit 13 latches on an auto-negotiation error.
// - Bit 12 latches when in SGMII mode a received page has selector 0.
// - Bit 11 latches when synchronization is lost.
// - Bit 10 latches when synchronization is achieved.
// - Bit 9 latches on a configuration indication from receive.
// - Bit 8 latches on an idle indication from receive.
// - Bit 7 latches on an invalid indication from receive.
// - Bit 6 latches when a link drops after sync loss over 10 ms.
// - Bit 5 latches on entry to the idle-detect negotiation state.
// - Bit 4 latches on entry to the complete-acknowledge state.
// - Bit 3 latches on entry to the acknowledge-detect state.
// - Bit 2 latches on entry to the ability-detect state.
// - Bit 1 latches on entry to link-up with negotiation disabled.
// - Bit 0 latches on entry to the negotiation-enable state.
module sesev_status_bank
  import sesev_pkg::*;
#(
  parameter int LOSS_CYCLES =
    (`SESEV_LINK_LOSS_MS * `SESEV_NS_PER_MS) / `SESEV_CLK_PERIOD_NS
) (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`SESEV_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire sesev_pcs_in_t [`SESEV_NUM_PORTS-1:0] pcs_in,
  output logic [`SESEV_NUM_PORTS-1:0]      event_pending
);

  // ==========================================================================
  // Declarations
  sesev_bus_state_t                   bus_state_q;
  logic [31:0]                        prdata_q;
  logic                               pready_q;
  logic                               pslverr_q;
  logic [`SESEV_NUM_PORTS-1:0]        event_pending_q;
  logic [`SESEV_FLAG_W-1:0]           capture_en_q;

  logic [15:0]                        reg_idx;
  logic [7:0]                         reg_page;
  logic [7:0]                         reg_off;
  logic [3:0]                         port_sel;
  logic                               aligned;
  logic                               hit_status;
  logic                               hit_ctrl;
  logic                               hit_pend;
  logic                               hit_any;
  logic                               access;
  logic                               rd_take;
  logic                               wr_take;
  logic [31:0]                        rd_data;
  logic [`SESEV_NUM_PORTS-1:0]        clear_vec;
  logic [`SESEV_NUM_PORTS-1:0]        pend_vec;
  logic [`SESEV_FLAG_W-1:0]           port_events [`SESEV_NUM_PORTS];
  logic [`SESEV_FLAG_W-1:0]           port_flags  [`SESEV_NUM_PORTS];

  // ==========================================================================
  // Address decode; printed offsets are word indices
  assign reg_idx  = paddr[`SESEV_ADDR_W-1:2];
  assign reg_page = reg_idx[15:8];
  assign reg_off  = reg_idx[7:0];
  assign port_sel = reg_page[3:0];
  assign aligned  = (paddr[1:0] == 2'h0);

  assign hit_status = aligned &&
                      (reg_page >= `SESEV_PAGE_FIRST) &&
                      (reg_page <= `SESEV_PAGE_LAST) &&
                      (reg_off == `SESEV_STATUS2_IDX);
  assign hit_ctrl   = aligned && (reg_idx == `SESEV_CTRL_IDX);
  assign hit_pend   = aligned && (reg_idx == `SESEV_PEND_IDX);
  assign hit_any    = hit_status || hit_ctrl || hit_pend;

  // One answer per access phase; the FSM blocks a second take
  assign access  = psel && penable && (bus_state_q == SESEV_BUS_IDLE);
  assign rd_take = access && !pwrite;
  assign wr_take = access && pwrite;

  // ==========================================================================
  // Per-port detection and flag storage
  genvar gp;
  generate
    for (gp = 0; gp < `SESEV_NUM_PORTS; gp++) begin : g_port
      logic [`SESEV_FLAG_W-1:0] gated;

      sesev_port_detect #(
        .LOSS_CYCLES (LOSS_CYCLES)
      ) u_detect (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pcs_in  (pcs_in[gp]),
        .events  (port_events[gp])
      );

      // Masked events are dropped, not deferred
      assign gated = port_events[gp] & capture_en_q;

      sesev_flag_reg u_flags (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .set_vec (gated),
        .clear   (clear_vec[gp]),
        .flags_q (port_flags[gp])
      );

      // Clear at the edge the read data is captured
      assign clear_vec[gp] = rd_take && hit_status &&
                             (port_sel == 4'(gp));
      assign pend_vec[gp]  = |port_flags[gp];
    end
  endgenerate

  // ==========================================================================
  // Read data mux
  always_comb begin
    rd_data = `SESEV_DATA_ZERO;
    if (hit_status) begin
      rd_data[`SESEV_FLAG_W-1:0] = port_flags[port_sel];
    end else if (hit_ctrl) begin
      rd_data[`SESEV_FLAG_W-1:0] = capture_en_q;
    end else if (hit_pend) begin
      rd_data[`SESEV_NUM_PORTS-1:0] = pend_vec;
    end
  end

  // ==========================================================================
  // Bus answer FSM: one wait state, pready from a flop
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bus_state_q <= SESEV_BUS_IDLE;
    end else begin
      unique case (bus_state_q)
        SESEV_BUS_IDLE: begin
          if (psel && penable) begin
            bus_state_q <= SESEV_BUS_DONE;
          end
        end
        SESEV_BUS_DONE: begin
          bus_state_q <= SESEV_BUS_IDLE;
        end
        default: begin
          bus_state_q <= SESEV_BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && !hit_any;
    end
  end

  // Read data holds until the next read so the bus sees stable data
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prdata_q <= `SESEV_DATA_ZERO;
    end else if (rd_take) begin
      prdata_q <= rd_data;
    end
  end

  // ==========================================================================
  // Capture enable; status itself is read-only and writes to it are ignored
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      capture_en_q <= `SESEV_CTRL_RST;
    end else if (wr_take && hit_ctrl) begin
      if (pstrb[0]) begin
        capture_en_q[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        capture_en_q[15:8] <= pwdata[15:8];
      end
    end
  end

  // ==========================================================================
  // Port summary output
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      event_pending_q <= '0;
    end else begin
      event_pending_q <= pend_vec;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign event_pending = event_pending_q;

endmodule

// >>> sesev_status_bank_checker.sv
// Port-level assertions for the SerDes event status bank
`timescale 1ns/1ps
`include "sesev_regs.svh"

// ==========================================================================
// Checker
module sesev_status_bank_checker
  import sesev_pkg::*;
#(
  parameter int LOSS_CYCLES = 20
) (
  input  wire logic                                  clk_sys,
  input  wire logic                                  resetn,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [`SESEV_ADDR_W-1:0]              paddr,
  input  wire logic [31:0]                           pwdata,
  input  wire logic [3:0]                            pstrb,
  input  wire logic [31:0]                           prdata,
  input  wire logic                                  pready,
  input  wire logic                                  pslverr,
  input  wire sesev_pcs_in_t [`SESEV_NUM_PORTS-1:0]  pcs_in,
  input  wire logic [`SESEV_NUM_PORTS-1:0]           event_pending
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_ready_one;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("no ready after access");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");

  property p_ready_cause;
    pready |-> $past(psel) && $past(penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");

  property p_err_unaligned;
    psel && penable && !pready && (paddr[1:0] != 2'b00) |=> pready && pslverr;
  endproperty
  a_err_unaligned: assert property (p_err_unaligned) else $error("unaligned accepted");

  property p_ctrl_ok;
    psel && penable && !pready && (paddr == {`SESEV_CTRL_IDX, 2'b00}) |=> !pslverr;
  endproperty
  a_ctrl_ok: assert property (p_ctrl_ok) else $error("control access refused");

  property p_rd_err_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_rd_err_zero: assert property (p_rd_err_zero) else $error("refused read gave data");

  property p_status_hi;
    pready && !pwrite && (paddr[9:2] == `SESEV_STATUS2_IDX) |-> prdata[31:16] == 16'h0000;
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status upper bits set");

  // Read data only moves when a read completes, so a stale word never looks fresh
  property p_prdata_hold;
    $changed(prdata) |-> pready && !pwrite;
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");

  property p_rudi_pend;
    pcs_in[7].rudi_invalid |-> ##[1:3] event_pending[7];
  endproperty
  a_rudi_pend: assert property (p_rudi_pend) else $error("invalid not flagged");

  property p_sync_pend;
    $past(resetn) && $fell(pcs_in[11].sync_status) |-> ##[1:3] event_pending[11];
  endproperty
  a_sync_pend: assert property (p_sync_pend) else $error("sync loss not flagged");
endmodule

// >>> testbench.sv
// Self-checking testbench for the SerDes event status bank
`timescale 1ns/1ps
`include "sesev_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

// ==========================================================================
// Bench
module testbench
  import sesev_pkg::*;
;
  localparam int LOSS = 20;
  logic                                 clk_sys = 1'b0;
  logic                                 resetn  = 1'b0;
  logic                                 psel    = 1'b0;
  logic                                 penable = 1'b0;
  logic                                 pwrite  = 1'b0;
  logic [`SESEV_ADDR_W-1:0]             paddr   = '0;
  logic [31:0]                          pwdata  = '0;
  logic [3:0]                           pstrb   = 4'h0;
  logic [31:0]                          prdata;
  logic                                 pready;
  logic                                 pslverr;
  sesev_pcs_in_t [`SESEV_NUM_PORTS-1:0] pcs;
  logic [`SESEV_NUM_PORTS-1:0]          event_pending;
  logic [31:0]                          rd;
  logic                                 er;
  int                                   mismatches  = 0;
  int                                   checks_done = 0;
  localparam logic [17:0] CTRL_A = {`SESEV_CTRL_IDX, 2'b00};
  localparam logic [17:0] PEND_A = {`SESEV_PEND_IDX, 2'b00};

  always #50 clk_sys = ~clk_sys;

  sesev_status_bank #(.LOSS_CYCLES(LOSS)) sesev_status_bank_inst (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pcs_in(pcs),
    .event_pending(event_pending));

  function automatic logic [17:0] st_a(input int p);
    st_a = {`SESEV_PAGE_FIRST + 8'(p), `SESEV_STATUS2_IDX, 2'b00};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Held until ready is sampled high at a rising edge; data taken at that edge.
  // Only the watchdog ends a wait, so a dead slave still reaches the verdict.
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset;
    for (int p = 0; p < 16; p++) begin
      apb(1'b0, st_a(p), '0, 4'h0);
      `CHK(rd, 32'h0000_0000)
    end
    apb(1'b0, CTRL_A, '0, 4'h0);
    `CHK(rd, 32'h0000_FFFF)
    $display("test reset done");
  endtask

  // Port n carries the event of flag n, so every flag and every page is visited
  task automatic t_flags;
    logic [15:0] ex;
    for (int n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      case (n)
        15: pcs[n].sgmii_mode <= 1'b0;
        14: pcs[n].code_word_incompatible <= 1'b1;
        13: pcs[n].negotiation_error_seen <= 1'b1;
        12: begin pcs[n].page_rx_valid <= 1'b1; pcs[n].page_selector_bit <= 1'b0; end
        11, 10, 6: pcs[n].sync_status <= 1'b0;
        9: pcs[n].rudi_c <= 1'b1;
        8: pcs[n].rudi_i <= 1'b1;
        7: pcs[n].rudi_invalid <= 1'b1;
        5: pcs[n].an_state <= SESEV_AN_IDLE_DET;
        4: pcs[n].an_state <= SESEV_AN_COMPLETE_ACK;
        3: pcs[n].an_state <= SESEV_AN_ACK_DET;
        2: pcs[n].an_state <= SESEV_AN_ABILITY_DET;
        1: pcs[n].an_state <= SESEV_AN_OFF_LINK_OK;
        default: pcs[n].an_state <= SESEV_AN_ENABLE;
      endcase
      @(posedge clk_sys);
      pcs[n].code_word_incompatible <= 1'b0;
      pcs[n].negotiation_error_seen <= 1'b0;
      pcs[n].page_rx_valid <= 1'b0;
      {pcs[n].rudi_c, pcs[n].rudi_i, pcs[n].rudi_invalid} <= 3'b000;
      if (n == 10)
        pcs[n].sync_status <= 1'b1;
      if (n == 6)
        repeat (LOSS + 4) @(posedge clk_sys);
      ex = 16'h0001 << n;
      if (n == 10) ex = 16'h0C00; // sync lost then regained
      if (n == 6) ex = 16'h0840;  // loss plus link drop
      apb(1'b0, PEND_A, '0, 4'h0);
      `CHK(rd, {16'h0000, 16'h0001 << n})
      `CHK(event_pending, 16'h0001 << n)
      apb(1'b0, st_a(n), '0, 4'h0);
      `CHK(rd, {16'h0000, ex})
      apb(1'b0, st_a(n), '0, 4'h0);
      `CHK(rd, 32'h0000_0000)
    end
    $display("test flags done");
  endtask

  task automatic t_same_cycle;
    fork
      apb(1'b0, st_a(8), '0, 4'h0);
      begin
        repeat (2) @(posedge clk_sys);
        pcs[8].rudi_i <= 1'b1;
        @(posedge clk_sys);
        pcs[8].rudi_i <= 1'b0;
      end
    join
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, st_a(8), '0, 4'h0);
    `CHK(rd, 32'h0000_0100)
    $display("test same cycle done");
  endtask

  task automatic t_mask_err;
    apb(1'b1, CTRL_A, 32'h0000_FDFF, 4'h3);
    apb(1'b1, CTRL_A, 32'h0000_0000, 4'h0);
    apb(1'b0, CTRL_A, '0, 4'h0);
    `CHK(rd, 32'h0000_FDFF)
    @(posedge clk_sys);
    pcs[9].rudi_c <= 1'b1;
    // Mode is off on port 15, so a zero selector there is no conflict
    pcs[15].page_rx_valid <= 1'b1;
    pcs[15].page_selector_bit <= 1'b0;
    @(posedge clk_sys);
    pcs[9].rudi_c <= 1'b0;
    pcs[15].page_rx_valid <= 1'b0;
    apb(1'b0, st_a(9), '0, 4'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, st_a(15), '0, 4'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, CTRL_A, 32'h0000_FFFF, 4'h3);
    apb(1'b1, st_a(3), 32'h0000_FFFF, 4'hF);
    `CHK(er, 1'b0)
    apb(1'b0, st_a(3), '0, 4'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 18'h0FC08, '0, 4'h0);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    apb(1'b0, st_a(3) | 18'h00001, '0, 4'h0);
    `CHK(er, 1'b1)
    $display("test mask and errors done");
  endtask

  initial begin
    for (int p = 0; p < 16; p++) begin
      pcs[p] = '0;
      pcs[p].sgmii_mode = 1'b1;
      pcs[p].sync_status = 1'b1;
      pcs[p].page_selector_bit = 1'b1;
      pcs[p].link_up = (p == 6);
      pcs[p].an_state = SESEV_AN_OTHER;
    end
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_flags();
    t_same_cycle();
    t_mask_err();
    end_sim();
  end

  // Whole run needs about 400 cycles; this is about fifty times that
  initial begin
    #(20000 * 100);
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule

bind sesev_status_bank sesev_status_bank_checker #(.LOSS_CYCLES(LOSS_CYCLES))
  sesev_status_bank_checker_inst (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pcs_in(pcs_in),
    .event_pending(event_pending));
